// >>> core/bdc_pkg.sv
// Purpose: Constants, field positions and carrier types of the bridge DMA channel control.
// Assumes: One clock; registers reached through the block's own register port.
// Notes: What follows names each behaviour the channel keeps.
// What this block does
// - Writing one to go starts transfers; zero ignored; reads back zero.
// - Reset request from either bus resets an active channel; ignored when idle.
// - Active flag reads one while transferring, zero when idle.
// - Done sets on count expiry or processor done; channel then goes idle.
// - Separate PCI and local error flags; error, reset, done flags clear by writing one.
// - Command option picks plain memory commands or invalidate and read-line commands.
// - Nonzero watermark x requests PCI at 16x bytes, capped at 128 bytes when mastered; zero uses cache-line setting.
// - With decoding enabled, transfer code match qualifies the acknowledge strobe.
// - Type bit picks handshake or mastered; chaining bit picks direct or linked list.
// - Direction bit picks transfer direction; second control register mirrors it read-only.
// - Protocol bit picks older controller handshake or newer processor handshake.
// - Fast termination bits act only in older-controller handshake transfers.
// - Width bit makes the handshake local port 32-bit or 16-bit.
// - PCI address increments per word and wraps inside its 16-Mbyte block.
// - Count holds remaining bytes in words; drops by four per PCI data transfer.
// - Go does not start unless count is at least 16 bytes.
// - Packet loads update only count bits 19 to 2.
// - Local address is never incremented by the channel.
// - Port size field selects 32, 8 or 16 bits; invert bit flips byte order.
// - After each burst boundary of a mastered transfer, wait the coded local clock count before requesting.
// - Stop halts a mastered transfer after the bus cycle ends, then sets stopped.
package bdc_pkg;

  // Register offsets.
  localparam logic [11:0] BDC_OFS_CTRL = 12'h400;
  localparam logic [11:0] BDC_OFS_PADDR = 12'h404;
  localparam logic [11:0] BDC_OFS_COUNT = 12'h408;
  localparam logic [11:0] BDC_OFS_LADDR = 12'h40c;
  localparam logic [11:0] BDC_OFS_MOPT = 12'h410;
  localparam logic [31:0] BDC_RESET_VAL = 32'h0000_0000;

  // Field positions of channel_control_status.
  localparam int BDC_CS_GO = 31;
  localparam int BDC_CS_RSTREQ = 30;
  localparam int BDC_CS_ACT = 23;
  localparam int BDC_CS_RSTST = 22;
  localparam int BDC_CS_DONE = 21;
  localparam int BDC_CS_PERR = 20;
  localparam int BDC_CS_LERR = 19;
  localparam int BDC_CS_CMD = 18;
  localparam int BDC_CS_WM_LO = 12;
  localparam int BDC_CS_TC_LO = 8;
  localparam int BDC_CS_TCEN = 7;
  localparam int BDC_CS_CHAIN = 6;
  localparam int BDC_CS_MAST = 5;
  localparam int BDC_CS_DIR = 4;
  localparam int BDC_CS_HSSEL = 3;
  localparam int BDC_CS_DFT = 2;
  localparam int BDC_CS_SFT = 1;
  localparam int BDC_CS_HALF = 0;

  // Field positions of master_dma_options.
  localparam int BDC_MO_TC_LO = 28;
  localparam int BDC_MO_DIR = 27;
  localparam int BDC_MO_DSZ_LO = 25;
  localparam int BDC_MO_INV = 24;
  localparam int BDC_MO_WM_LO = 20;
  localparam int BDC_MO_OFF_LO = 16;
  localparam int BDC_MO_B4 = 15;
  localparam int BDC_MO_BEN = 14;
  localparam int BDC_MO_MAX_BURST_SIZE_SELECT = 9;
  localparam int BDC_MO_LOC = 8;
  localparam int BDC_MO_STOP = 7;
  localparam int BDC_MO_STST = 6;

  // Counts and limits.
  localparam logic [21:0] BDC_MIN_WORDS = 22'h00_0004;
  localparam logic [7:0] BDC_WM_MAX_HS = 8'hf0;
  localparam logic [7:0] BDC_WM_MAX_MS = 8'h80;
  localparam logic [5:0] BDC_BND_256 = 6'h3f;
  localparam logic [5:0] BDC_BND_64 = 6'h0f;

  // PCI bus commands.
  localparam logic [3:0] BDC_PCI_MR = 4'h6;
  localparam logic [3:0] BDC_PCI_MW = 4'h7;
  localparam logic [3:0] BDC_PCI_MRL = 4'he;
  localparam logic [3:0] BDC_PCI_MWI = 4'hf;

  typedef enum logic [2:0] {
    BDC_IDLE = 3'b001,
    BDC_RUN = 3'b010,
    BDC_HALT = 3'b100
  } bdc_state_t;

  // Decoded controls handed to the bus interface machines.
  typedef struct packed {
    logic mastered;
    logic linked;
    logic to_pci;
    logic new_handshake;
    logic dual_fast_term;
    logic slave_fast_term;
    logic half_port;
    logic [3:0] pci_cmd;
    logic [1:0] dest_port_size;
    logic byte_order;
    logic burst_en;
    logic burst_four;
    logic packet_location;
    logic [3:0] local_tc;
  } bdc_cfg_t;

  // Command packet contents loaded in linked-list mode.
  typedef struct packed {
    logic [31:2] pci_addr;
    logic [31:2] local_addr;
    logic [19:2] count;
    logic [11:0] options_top;
  } bdc_packet_t;

  // Back-off length in local clocks for each code; reserved codes give none.
  function automatic logic [10:0] bdc_off_cycles(input logic [2:0] code);
    case (code)
      3'h1: bdc_off_cycles = 11'h040;
      3'h2: bdc_off_cycles = 11'h080;
      3'h3: bdc_off_cycles = 11'h100;
      3'h4: bdc_off_cycles = 11'h200;
      3'h5: bdc_off_cycles = 11'h400;
      default: bdc_off_cycles = 11'h000;
    endcase
  endfunction

endpackage

// >>> core/bdc_off_timer.sv
// Purpose: Local bus back-off timer of the bridge DMA channel.
// Assumes: The local clock is the block clock.
// Notes: A start while counting reloads the timer.
module bdc_off_timer
  import bdc_pkg::*;
(
  input wire logic clk_in, // Block clock.
  input wire logic rst_in, // Asynchronous reset, active high.
  input wire logic start_in, // Burst boundary crossed.
  input wire logic [2:0] code_in, // Back-off code.
  output logic busy_out // Local bus requests held off.
);

  logic [10:0] cnt_q;
  logic [10:0] cnt_d;
  logic [10:0] load;

  // Load the coded length on a start, else count down to zero.
  assign load = bdc_off_cycles(code_in);
  assign cnt_d = start_in ? load : (cnt_q != 11'h000) ? cnt_q - 11'h001 : cnt_q;
  assign busy_out = (cnt_q != 11'h000);

  // Counter register.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cnt_q <= 11'h000;
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end

endmodule

// >>> core/bdc_channel.sv
// Purpose: Control, status, address and count registers of the bridge DMA channel.
// Assumes: Bus interface machines report each PCI word, local word, error and idle state.
// Notes: Register accesses from either bus arrive on one port; reads answer next cycle.
module bdc_channel
  import bdc_pkg::*;
(
  input wire logic clk_in, // Block clock, 250 MHz.
  input wire logic rst_in, // Global reset, asynchronous, active high.
  input wire logic reg_wr_in, // Register write strobe.
  input wire logic reg_rd_in, // Register read strobe.
  input wire logic [11:0] reg_addr_in, // Register offset.
  input wire logic [31:0] reg_wdata_in, // Write data.
  output logic [31:0] reg_rdata_out, // Read data, registered.
  output logic reg_ack_out, // Access answered, one-cycle pulse.
  input wire logic pkt_load_in, // Command packet loaded, one-cycle pulse.
  input wire bdc_packet_t pkt_in, // Command packet contents.
  input wire logic pci_word_in, // One 32-bit PCI data transfer done.
  input wire logic local_word_in, // One word moved on the local bus.
  input wire logic pci_err_in, // PCI bus error during transfer.
  input wire logic local_err_in, // Local bus error during transfer.
  input wire logic bus_busy_in, // A bus cycle is still in progress.
  input wire logic hs_done_pin_in, // Processor done pin, active high.
  input wire logic [3:0] tc_pins_in, // Processor transfer code pins.
  input wire logic global_byte_order_in, // Global local bus byte order.
  input wire logic [7:0] cache_line_setting_in, // Cache-line watermark in bytes.
  input wire logic [7:0] fifo_bytes_in, // Bytes queued in the inbound FIFO.
  output bdc_cfg_t cfg_out, // Decoded channel controls.
  output logic active_out, // Transfer in progress.
  output logic pci_req_ok_out, // Watermark reached, PCI may be requested.
  output logic local_req_ok_out, // Local bus may be requested.
  output logic ack_qual_out, // Qualifier for the handshake acknowledge.
  output logic [7:0] watermark_out // PCI request threshold in bytes.
);

  bdc_state_t st_q;
  bdc_state_t st_d;
  logic [31:0] cs_q;
  logic [31:2] padd_q;
  logic [23:2] cnt_q;
  logic [31:2] ladd_q;
  logic [31:0] mo_q;
  logic [31:0] rdata_q;
  logic ack_q;
  logic [1:0] done_s_q;
  logic [3:0] tc_s1_q;
  logic [3:0] tc_s2_q;
  logic [7:2] lbyte_q;

  // Address decode, one wire per register.
  logic wr_cs;
  logic wr_pa;
  logic wr_cn;
  logic wr_la;
  logic wr_mo;
  assign wr_cs = reg_wr_in && (reg_addr_in == BDC_OFS_CTRL);
  assign wr_pa = reg_wr_in && (reg_addr_in == BDC_OFS_PADDR);
  assign wr_cn = reg_wr_in && (reg_addr_in == BDC_OFS_COUNT);
  assign wr_la = reg_wr_in && (reg_addr_in == BDC_OFS_LADDR);
  assign wr_mo = reg_wr_in && (reg_addr_in == BDC_OFS_MOPT);

  // Channel events.
  logic idle;
  logic go_wr;
  logic start;
  logic rst_req;
  logic last_word;
  logic hs_done;
  logic finish;
  logic stop_bit;
  logic halt_now;
  logic hs_mode;
  assign idle = (st_q == BDC_IDLE);
  assign hs_mode = !cs_q[BDC_CS_MAST];
  assign go_wr = wr_cs && reg_wdata_in[BDC_CS_GO];
  assign start = go_wr && idle && (cnt_q >= BDC_MIN_WORDS);
  assign rst_req = wr_cs && reg_wdata_in[BDC_CS_RSTREQ] && !idle;
  assign last_word = pci_word_in && (st_q == BDC_RUN) && (cnt_q == 22'h00_0001);
  assign hs_done = done_s_q[1] && hs_mode && !idle;
  assign finish = !rst_req && (last_word || hs_done);
  assign stop_bit = wr_mo ? reg_wdata_in[BDC_MO_STOP] : mo_q[BDC_MO_STOP];
  assign halt_now = stop_bit && cs_q[BDC_CS_MAST] && !bus_busy_in;

  // Channel state machine.
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      BDC_IDLE:
      begin
        if (start)
          st_d = BDC_RUN;
      end
      BDC_RUN:
      begin
        if (rst_req || finish)
          st_d = BDC_IDLE;
        else if (halt_now)
          st_d = BDC_HALT;
      end
      BDC_HALT:
      begin
        if (rst_req || hs_done)
          st_d = BDC_IDLE;
        else if (!stop_bit)
          st_d = BDC_RUN;
      end
      default:
        st_d = BDC_IDLE;
    endcase
  end

  // Sticky status flags: a hardware set wins over a write-one clear.
  logic rst_st_d;
  logic done_d;
  logic perr_d;
  logic lerr_d;
  logic [31:0] w1c;
  assign w1c = wr_cs ? reg_wdata_in : 32'h0000_0000;
  assign rst_st_d = rst_req || (cs_q[BDC_CS_RSTST] && !w1c[BDC_CS_RSTST]);
  assign done_d = finish || (cs_q[BDC_CS_DONE] && !w1c[BDC_CS_DONE]);
  assign perr_d = (pci_err_in && !idle) || (cs_q[BDC_CS_PERR] && !w1c[BDC_CS_PERR]);
  assign lerr_d = (local_err_in && !idle) || (cs_q[BDC_CS_LERR] && !w1c[BDC_CS_LERR]);

  // Control register next value; go and reset request are never stored.
  logic [31:0] cs_d;
  assign cs_d = {2'b00, 6'h00, 1'b0, rst_st_d, done_d, perr_d, lerr_d,
                 wr_cs ? reg_wdata_in[18:0] : cs_q[18:0]} &
                ~(32'h1 << BDC_CS_ACT);

  // Options register next value; mirror bit stored as zero, stopped bit follows the channel.
  logic [31:0] mo_wr;
  logic [31:0] mo_d;
  logic stopped_d;
  assign mo_wr = wr_mo ? reg_wdata_in : mo_q;
  assign stopped_d = (st_d == BDC_HALT);
  assign mo_d = {pkt_load_in ? {pkt_in.options_top[11:8], 1'b0, pkt_in.options_top[6:0]}
                             : {mo_wr[31:28], 1'b0, mo_wr[26:20]},
                 1'b0, mo_wr[18:14], 4'h0, mo_wr[9:7], stopped_d, 6'h00};

  // PCI address steps a word and wraps inside its 16-Mbyte block.
  logic [31:2] padd_d;
  assign padd_d = pkt_load_in ? pkt_in.pci_addr :
                  wr_pa ? reg_wdata_in[31:2] :
                  (pci_word_in && st_q == BDC_RUN) ?
                  {padd_q[31:24], padd_q[23:2] + 22'h00_0001} : padd_q;

  // Count drops one word per PCI data transfer; packets touch bits 19 to 2 only.
  logic [23:2] cnt_d;
  assign cnt_d = pkt_load_in ? {cnt_q[23:20], pkt_in.count} :
                 wr_cn ? reg_wdata_in[23:2] :
                 (pci_word_in && st_q == BDC_RUN && !rst_req) ?
                 cnt_q - 22'h00_0001 : cnt_q;

  // Local address is loaded only, never stepped.
  logic [31:2] ladd_d;
  assign ladd_d = pkt_load_in ? pkt_in.local_addr :
                  wr_la ? reg_wdata_in[31:2] : ladd_q;

  // Read data mux.
  logic [31:0] rd_mux;
  assign rd_mux = (reg_addr_in == BDC_OFS_CTRL) ? (cs_q | ({31'h0, !idle} << BDC_CS_ACT)) :
                  (reg_addr_in == BDC_OFS_PADDR) ? {padd_q, 2'b00} :
                  (reg_addr_in == BDC_OFS_COUNT) ? {8'h00, cnt_q, 2'b00} :
                  (reg_addr_in == BDC_OFS_LADDR) ? {ladd_q, 2'b00} :
                  (reg_addr_in == BDC_OFS_MOPT) ? mo_q | ({31'h0, cs_q[BDC_CS_DIR]} << BDC_MO_DIR) :
                  32'h0000_0000;

  // Register file and state.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st_q <= BDC_IDLE;
      cs_q <= BDC_RESET_VAL;
      padd_q <= 30'h0000_0000;
      cnt_q <= 22'h00_0000;
      ladd_q <= 30'h0000_0000;
      mo_q <= BDC_RESET_VAL;
    end
    else
    begin
      st_q <= st_d;
      cs_q <= cs_d;
      padd_q <= padd_d;
      cnt_q <= cnt_d;
      ladd_q <= ladd_d;
      mo_q <= mo_d;
    end
  end

  // Read answer, one cycle after the strobe.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rdata_q <= 32'h0000_0000;
      ack_q <= 1'b0;
    end
    else
    begin
      rdata_q <= reg_rd_in ? rd_mux : rdata_q;
      ack_q <= reg_rd_in || reg_wr_in;
    end
  end

  // Pin synchronisers for the done and transfer code pins.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      done_s_q <= 2'b00;
      tc_s1_q <= 4'h0;
      tc_s2_q <= 4'h0;
    end
    else
    begin
      done_s_q <= {done_s_q[0], hs_done_pin_in};
      tc_s1_q <= tc_pins_in;
      tc_s2_q <= tc_s1_q;
    end
  end

  // Local burst boundary tracking: word offset within the burst window.
  logic [5:0] bnd;
  logic crossed;
  assign bnd = mo_q[BDC_MO_MAX_BURST_SIZE_SELECT] ? BDC_BND_64 : BDC_BND_256;
  assign crossed = local_word_in && !idle && ((lbyte_q & bnd) == bnd);
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      lbyte_q <= 6'h00;
    end
    else
    begin
      lbyte_q <= start ? 6'h00 : (local_word_in && !idle) ? lbyte_q + 6'h01 : lbyte_q;
    end
  end

  logic off_busy;
  bdc_off_timer u_off (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .start_in(crossed && cs_q[BDC_CS_MAST]),
    .code_in(mo_q[BDC_MO_OFF_LO +: 3]),
    .busy_out(off_busy)
  );

  // Watermark: 16 bytes per step, capped per transfer type, zero uses cache line.
  logic [3:0] wm;
  logic [7:0] wm_raw;
  logic [7:0] wm_cap;
  assign wm = hs_mode ? cs_q[BDC_CS_WM_LO +: 4] : mo_q[BDC_MO_WM_LO +: 4];
  assign wm_raw = {wm, 4'h0};
  assign wm_cap = hs_mode ? BDC_WM_MAX_HS : BDC_WM_MAX_MS;
  assign watermark_out = (wm == 4'h0) ? cache_line_setting_in :
                         (wm_raw > wm_cap) ? wm_cap : wm_raw;
  assign pci_req_ok_out = (st_q == BDC_RUN) && (fifo_bytes_in >= watermark_out);

  // Handshake acknowledge qualifier from transfer code match.
  assign ack_qual_out = !cs_q[BDC_CS_TCEN] || (tc_s2_q == cs_q[BDC_CS_TC_LO +: 4]);

  // Decoded controls.
  logic old_hs;
  assign old_hs = hs_mode && !cs_q[BDC_CS_HSSEL];
  assign cfg_out.mastered = cs_q[BDC_CS_MAST];
  assign cfg_out.linked = cs_q[BDC_CS_CHAIN];
  assign cfg_out.to_pci = cs_q[BDC_CS_DIR];
  assign cfg_out.new_handshake = cs_q[BDC_CS_HSSEL];
  assign cfg_out.dual_fast_term = old_hs && cs_q[BDC_CS_DFT];
  assign cfg_out.slave_fast_term = old_hs && cs_q[BDC_CS_SFT];
  assign cfg_out.half_port = hs_mode && cs_q[BDC_CS_HALF];
  assign cfg_out.pci_cmd = cs_q[BDC_CS_DIR] ?
                           (cs_q[BDC_CS_CMD] ? BDC_PCI_MWI : BDC_PCI_MW) :
                           (cs_q[BDC_CS_CMD] ? BDC_PCI_MRL : BDC_PCI_MR);
  assign cfg_out.dest_port_size = mo_q[BDC_MO_DSZ_LO +: 2];
  assign cfg_out.byte_order = global_byte_order_in ^ mo_q[BDC_MO_INV];
  assign cfg_out.burst_en = mo_q[BDC_MO_BEN];
  assign cfg_out.burst_four = mo_q[BDC_MO_B4];
  assign cfg_out.packet_location = mo_q[BDC_MO_LOC];
  assign cfg_out.local_tc = mo_q[BDC_MO_TC_LO +: 4];

  assign active_out = !idle;
  assign local_req_ok_out = (st_q == BDC_RUN) && !off_busy;
  assign reg_rdata_out = rdata_q;
  assign reg_ack_out = ack_q;

  // Checks of channel behaviour.
  property p_go_reads_zero;
    @(posedge clk_in) disable iff (rst_in)
    reg_rd_in && reg_addr_in == BDC_OFS_CTRL |=> !reg_rdata_out[BDC_CS_GO];
  endproperty
  a_go_reads_zero: assert property (p_go_reads_zero) else $error("go bit read one");

  property p_reset_active;
    @(posedge clk_in) disable iff (rst_in)
    rst_req |=> !active_out && cs_q[BDC_CS_RSTST];
  endproperty
  a_reset_active: assert property (p_reset_active) else $error("reset not taken");

  property p_reset_idle;
    @(posedge clk_in) disable iff (rst_in)
    idle && !cs_q[BDC_CS_RSTST] && wr_cs |=> !cs_q[BDC_CS_RSTST];
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("idle reset took effect");

  property p_done_last;
    @(posedge clk_in) disable iff (rst_in)
    last_word && !rst_req |=> cs_q[BDC_CS_DONE] && !active_out && cnt_q == 22'h00_0000;
  endproperty
  a_done_last: assert property (p_done_last) else $error("done not set at count end");

  property p_count_step;
    @(posedge clk_in) disable iff (rst_in)
    pci_word_in && st_q == BDC_RUN && !rst_req && !pkt_load_in && !wr_cn
    |=> cnt_q == $past(cnt_q) - 22'h00_0001;
  endproperty
  a_count_step: assert property (p_count_step) else $error("count step wrong");

  property p_addr_wrap;
    @(posedge clk_in) disable iff (rst_in)
    pci_word_in && st_q == BDC_RUN && !pkt_load_in && !wr_pa
    |=> padd_q[31:24] == $past(padd_q[31:24]);
  endproperty
  a_addr_wrap: assert property (p_addr_wrap) else $error("address left its block");

  property p_min_count;
    @(posedge clk_in) disable iff (rst_in)
    go_wr && idle && cnt_q < BDC_MIN_WORDS |=> !active_out;
  endproperty
  a_min_count: assert property (p_min_count) else $error("started below minimum");

  property p_stop_halts;
    @(posedge clk_in) disable iff (rst_in)
    st_q == BDC_RUN && halt_now && !rst_req && !finish |=> mo_q[BDC_MO_STST] ##1 !pci_req_ok_out;
  endproperty
  a_stop_halts: assert property (p_stop_halts) else $error("stop not honoured");

  property p_tc_qual;
    @(posedge clk_in) disable iff (rst_in)
    cs_q[BDC_CS_TCEN] && $past(tc_pins_in, 2) != cs_q[BDC_CS_TC_LO +: 4] |-> !ack_qual_out;
  endproperty
  a_tc_qual: assert property (p_tc_qual) else $error("code mismatch acknowledged");

endmodule

// >>> verif/bdc_far_model.sv
// Purpose: Far-side bus machine model that reports PCI words to the channel.
// Assumes: Outputs change at the falling edge, only while the channel is active.
// Notes: Words come at random gaps so that a stop can find the bus quiet.
module bdc_far_model
(
  input wire logic clk_in, // Block clock.
  input wire logic active_in, // Channel active.
  input wire logic en_in, // Model allowed to move data.
  output logic pci_word_out, // One PCI word done.
  output logic bus_busy_out // Bus cycle in progress.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic word;

  initial pci_word_out = 1'b0;
  initial bus_busy_out = 1'b0;

  // A word at random gaps while active; busy rides along with each word.
  always @(negedge clk_in)
  begin
    word = active_in && en_in && ($urandom_range(3, 0) == 0);
    pci_word_out <= word;
    bus_busy_out <= word;
  end
endmodule

// >>> verif/bridge_dma_channel_control_tb_top.sv
// Purpose: Self-checking bench of the bridge DMA channel registers and status.
// Assumes: Inputs change at the falling edge; expectations are worked out inline in the bench.
// Notes: The far model gives PCI words; the bench drives packets, local words and the done pin.
module bridge_dma_channel_control_tb_top
  import bdc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0, rst_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic [11:0] reg_addr_in = 12'h000;
  logic [31:0] reg_wdata_in = 32'h0000_0000, reg_rdata_out, d, c1, pad;
  logic reg_ack_out, pci_word_in, bus_busy_in, active_out, pci_req_ok_out, ack_qual_out;
  logic local_req_ok_out, hs_done_pin_in = 1'b0, local_word_in = 1'b0, pkt_load_in = 1'b0;
  logic pci_err_in = 1'b0, local_err_in = 1'b0, global_byte_order_in = 1'b0, fen = 1'b0;
  logic [3:0] tc_pins_in = 4'h0, e;
  logic [7:0] cache_line_setting_in = 8'h00, fifo_bytes_in = 8'h00, watermark_out;
  bdc_cfg_t cfg_out;
  bdc_packet_t pkt_in = '0;
  int num_errors = 0, cmp_count = 0, i;

  bdc_channel dut (.clk_in, .rst_in, .reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_wdata_in,
    .reg_rdata_out, .reg_ack_out, .pkt_load_in, .pkt_in, .pci_word_in,
    .local_word_in, .pci_err_in, .local_err_in, .bus_busy_in, .hs_done_pin_in,
    .tc_pins_in, .global_byte_order_in, .cache_line_setting_in, .fifo_bytes_in, .cfg_out,
    .active_out, .pci_req_ok_out, .local_req_ok_out, .ack_qual_out, .watermark_out);
  bdc_far_model far (.clk_in, .active_in(active_out), .en_in(fen),
    .pci_word_out(pci_word_in), .bus_busy_out(bus_busy_in));

  // Free-running block clock.
  always #2 clk_in = ~clk_in;

  // Compares one value and counts the outcome.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic give_verdict();
    if (num_errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // One register write, strobe held for one edge.
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(negedge clk_in);
    reg_wr_in = 1'b1;
    reg_addr_in = a;
    reg_wdata_in = v;
    @(negedge clk_in);
    reg_wr_in = 1'b0;
  endtask

  // One register read; data and acknowledge land one edge after the strobe.
  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    @(negedge clk_in);
    reg_rd_in = 1'b1;
    reg_addr_in = a;
    @(negedge clk_in);
    reg_rd_in = 1'b0;
    chk({31'h0, reg_ack_out}, 32'h0000_0001);
    v = reg_rdata_out;
  endtask

  // Stops a hung run.
  initial
  begin
    #200us;
    num_errors++;
    give_verdict();
  end

  // Main sequence of scenarios.
  initial
  begin
    i = $urandom(32'h88bc);
    cache_line_setting_in = 8'($urandom);
    global_byte_order_in = 1'($urandom);
    repeat (16) @(negedge clk_in);
    rst_in = 1'b0;
    // Reset values, unmapped offset included.
    for (i = 0; i < 6; i++)
    begin
      rd(12'h400 + 12'(4 * i), d);
      chk(d, BDC_RESET_VAL);
    end
    chk({31'h0, ack_qual_out}, 32'h0000_0001);
    // Every command choice per direction, with the read-only direction mirror.
    for (i = 0; i < 4; i++)
    begin
      wr(BDC_OFS_CTRL, {13'h0000, i[1], 13'h0000, i[0], 4'h0});
      e = i[1] ? (i[0] ? BDC_PCI_MWI : BDC_PCI_MRL) : (i[0] ? BDC_PCI_MW : BDC_PCI_MR);
      chk({28'h0, cfg_out.pci_cmd}, {28'h0, e});
      rd(BDC_OFS_MOPT, d);
      chk({31'h0, d[27]}, {31'h0, i[0]});
    end
    // Random control low byte and option word against decode and read-back.
    repeat (8)
    begin
      c1 = $urandom & 32'h0000_00ff;
      pad = $urandom;
      wr(BDC_OFS_CTRL, c1);
      wr(BDC_OFS_MOPT, pad);
      e = {2'b00, {2{!c1[5] && !c1[3]}} & c1[2:1]};
      chk({30'h0, cfg_out.mastered, cfg_out.linked}, {30'h0, c1[5], c1[6]});
      chk({31'h0, cfg_out.new_handshake}, {31'h0, c1[3]});
      chk({30'h0, cfg_out.dual_fast_term, cfg_out.slave_fast_term}, {28'h0, e});
      chk({31'h0, cfg_out.half_port}, {31'h0, !c1[5] && c1[0]});
      chk({30'h0, cfg_out.dest_port_size}, {30'h0, pad[26:25]});
      rd(BDC_OFS_MOPT, d);
      chk(d, (pad & 32'hf7f7_c380) | {4'h0, c1[4], 27'h0});
    end
    wr(BDC_OFS_MOPT, 32'h0100_0000);
    chk({31'h0, cfg_out.byte_order}, {31'h0, ~global_byte_order_in});
    // Go with only 12 bytes left must not start.
    wr(BDC_OFS_CTRL, 32'h0000_0000);
    chk({24'h0, watermark_out}, {24'h0, cache_line_setting_in});
    wr(BDC_OFS_COUNT, 32'h0000_000c);
    wr(BDC_OFS_CTRL, 32'h8000_0000);
    chk({31'h0, active_out}, 32'h0000_0000);
    // Handshake run of 16 bytes across the 16-Mbyte address wrap.
    pad = 32'h12ff_fff8;
    wr(BDC_OFS_PADDR, pad);
    wr(BDC_OFS_COUNT, 32'h0000_0010);
    fen = 1'b1;
    wr(BDC_OFS_CTRL, 32'h8000_0000);
    chk({31'h0, active_out}, 32'h0000_0001);
    rd(BDC_OFS_CTRL, d);
    chk({31'h0, d[31]}, 32'h0000_0000);
    for (i = 0; i < 300 && active_out; i++)
      @(negedge clk_in);
    rd(BDC_OFS_CTRL, d);
    chk(d, 32'h0020_0000);
    rd(BDC_OFS_COUNT, d);
    chk(d, 32'h0000_0000);
    rd(BDC_OFS_PADDR, d);
    chk(d, (pad & 32'hff00_0000) | ((pad + 32'h10) & 32'h00ff_ffff));
    wr(BDC_OFS_CTRL, 32'h0020_0000);
    rd(BDC_OFS_CTRL, d);
    chk(d, 32'h0000_0000);
    // Held handshake run: watermark, code match, errors, then a reset request.
    fen = 1'b0;
    wr(BDC_OFS_COUNT, 32'h0000_0040);
    wr(BDC_OFS_CTRL, 32'h8000_3580);
    chk({24'h0, watermark_out}, 32'h0000_0030);
    fifo_bytes_in = 8'h2f;
    @(negedge clk_in);
    chk({31'h0, pci_req_ok_out}, 32'h0000_0000);
    fifo_bytes_in = 8'h30;
    tc_pins_in = 4'h5;
    repeat (4) @(negedge clk_in);
    chk({31'h0, pci_req_ok_out}, 32'h0000_0001);
    chk({31'h0, ack_qual_out}, 32'h0000_0001);
    tc_pins_in = 4'($urandom_range(15, 6));
    pci_err_in = 1'b1;
    local_err_in = 1'b1;
    @(negedge clk_in);
    pci_err_in = 1'b0;
    local_err_in = 1'b0;
    repeat (3) @(negedge clk_in);
    chk({31'h0, ack_qual_out}, 32'h0000_0000);
    wr(BDC_OFS_CTRL, 32'h4000_3580);
    chk({31'h0, active_out}, 32'h0000_0000);
    rd(BDC_OFS_CTRL, d);
    chk(d, 32'h0058_3580);
    wr(BDC_OFS_CTRL, 32'h0058_0000);
    wr(BDC_OFS_CTRL, 32'h4000_0000);
    rd(BDC_OFS_CTRL, d);
    chk(d, 32'h0000_0000);
    // Processor done pin ends a handshake run after two synchroniser stages.
    wr(BDC_OFS_CTRL, 32'h8000_0000);
    hs_done_pin_in = 1'b1;
    repeat (2) @(negedge clk_in);
    chk({31'h0, active_out}, 32'h0000_0001);
    @(negedge clk_in);
    hs_done_pin_in = 1'b0;
    chk({31'h0, active_out}, 32'h0000_0000);
    rd(BDC_OFS_CTRL, d);
    chk(d, 32'h0020_0000);
    wr(BDC_OFS_CTRL, 32'h0020_0000);
    // Mastered run stopped mid-way: no words counted while halted, then resumed.
    fen = 1'b1;
    wr(BDC_OFS_COUNT, 32'h0000_0100);
    wr(BDC_OFS_CTRL, 32'h8000_0020);
    wr(BDC_OFS_MOPT, 32'h0000_0080);
    for (i = 0; i < 50 && !d[6]; i++)
      rd(BDC_OFS_MOPT, d);
    chk({31'h0, d[6]}, 32'h0000_0001);
    rd(BDC_OFS_COUNT, c1);
    repeat (20) @(negedge clk_in);
    rd(BDC_OFS_COUNT, d);
    chk(d, c1);
    fen = 1'b0;
    wr(BDC_OFS_MOPT, 32'h0000_0000);
    rd(BDC_OFS_MOPT, d);
    chk({31'h0, d[6]}, 32'h0000_0000);
    chk({31'h0, active_out}, 32'h0000_0001);
    // Back-off: sixteen local words cross a 64-byte burst, then 64 clocks of hold-off.
    wr(BDC_OFS_MOPT, 32'h00f1_0200);
    chk({24'h0, watermark_out}, 32'h0000_0080);
    chk({31'h0, local_req_ok_out}, 32'h0000_0001);
    local_word_in = 1'b1;
    repeat (16) @(negedge clk_in);
    local_word_in = 1'b0;
    chk({31'h0, local_req_ok_out}, 32'h0000_0000);
    repeat (63) @(negedge clk_in);
    chk({31'h0, local_req_ok_out}, 32'h0000_0000);
    @(negedge clk_in);
    chk({31'h0, local_req_ok_out}, 32'h0000_0001);
    wr(BDC_OFS_CTRL, 32'h4000_0020);
    chk({31'h0, active_out}, 32'h0000_0000);
    // Packet load keeps count bits 23 to 20 and ignores the packet's direction bit.
    wr(BDC_OFS_COUNT, 32'h00ff_fffc);
    pkt_in = {30'($urandom), 30'($urandom), 18'($urandom), 12'($urandom)};
    pkt_load_in = 1'b1;
    @(negedge clk_in);
    pkt_load_in = 1'b0;
    rd(BDC_OFS_COUNT, d);
    chk(d, {8'h00, 4'hf, pkt_in.count, 2'b00});
    rd(BDC_OFS_LADDR, d);
    chk(d, {pkt_in.local_addr, 2'b00});
    rd(BDC_OFS_MOPT, d);
    chk(d, ({pkt_in.options_top, 20'h0_0000} & 32'hf7f0_0000) | 32'h0001_0200);
    give_verdict();
  end
endmodule
